// ===== src/pcs_card_power_ctrl.v
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.vh"

// Summary of operation
// [RULE1] Sample serial data on serial clock rise.
// [RULE2] Latch rise moves shifted word to active.
// [RULE3] Host raises latch before next clock rise.
// [RULE4] Shutdown forces all supply outputs high-impedance.
// [RULE5] Reset closes only the four ground switches.
// [RULE6] Stay grounded until reset released, word latched.
// [RULE7] Latch edges ignored while reset is asserted.
// [RULE8] Fault flag low on overcurrent or overtemperature.
// [RULE9] Current limit only on the faulting output.
// [RULE10] Overtemperature turns off all outputs until cleared.
// [RULE11] 12 V selected and present drives pump.
// [RULE12] Every output has a controllable discharge switch.
// [RULE13] Host discharges below 0.8 V before 3.3 V.
// [RULE14] Host powers at 5 V, then polls card.
// [RULE15] Shutdown by low pin or word bit zero.
// [RULE16] Bit 10 shifted first, bit 0 last.
// [RULE17] Power-on reset enters the grounded state.
module pcs_card_power_ctrl (
  input wire core_clk,
  input wire reset,
  input wire serial_data,
  input wire serial_clk,
  input wire serial_latch,
  input wire card_reset_n,
  input wire power_down_request_n,
  input wire over_temp,
  input wire high_supply_present,
  input wire [3:0] overcurrent_sense,
  input wire fault_flag_n_in,
  output reg fault_flag_n_out_q,
  output reg fault_flag_n_oe_n_q,
  output reg [1:0] card_main_supply_out_a_q,
  output reg [1:0] card_main_supply_out_b_q,
  output reg [1:0] card_program_supply_out_a_q,
  output reg [1:0] card_program_supply_out_b_q,
  output reg [3:0] output_hiz_q,
  output reg ground_switch_a_q,
  output reg ground_switch_b_q,
  output reg ground_switch_c_q,
  output reg ground_switch_d_q,
  output reg [3:0] current_limit_q,
  output reg [1:0] pump_from_high_supply_q,
  input wire [`PCS_ADDR_W-1:0] reg_addr,
  input wire [`PCS_DATA_W-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [`PCS_DATA_W-1:0] reg_rdata_q,
  output reg irq_q
);

  // Output index order used by every 4-bit vector below:
  // 0 main A, 1 program A, 2 main B, 3 program B.

  // Control word layout; bit 10 arrives first on the link.
  // Bits 1:0 pick the socket A program level, and bit 9 picks 5 V over 3.3 V.
  // Bits 3:2 pick the socket A main level.
  // Bits 5:4 pick the socket B program level, and bit 10 picks 5 V over 3.3 V.
  // Bits 7:6 pick the socket B main level.
  // Bit 8 low asks for power-down, which floats every output.
  // A program selection with both bits set floats that output alone.
  // A main selection with both bits set, or both clear, grounds the output.

  wire [11:0] pins_raw;
  wire [11:0] pins_s;
  wire data_s;
  wire sclk_s;
  wire latch_s;
  wire card_reset_n_s;
  wire pwrdn_pin_n_s;
  wire over_temp_s;
  wire high_present_s;
  wire fault_pin_s;
  wire [3:0] oc_s;

  reg sclk_prev_q;
  reg latch_prev_q;
  reg over_temp_prev_q;
  reg [3:0] oc_prev_q;
  wire sclk_rise;
  wire latch_rise;
  wire card_reset_active;

  wire [`PCS_WORD_W-1:0] shift_word;
  wire [`PCS_WORD_W-1:0] active_word;
  wire word_valid;

  reg [`PCS_EV_W-1:0] status_q;
  reg [`PCS_EV_W-1:0] mask_q;
  reg [`PCS_EV_W-1:0] events;
  reg status_rd;

  reg grounded;
  reg all_off;
  reg [1:0] lvl_main_a;
  reg [1:0] lvl_main_b;
  reg [1:0] lvl_prog_a;
  reg [1:0] lvl_prog_b;
  reg [3:0] hiz_d;
  reg [3:0] discharge_d;
  reg [1:0] pump_d;
  reg any_fault;
  reg [`PCS_DATA_W-1:0] rdata_d;

  // Every pin from outside the core clock domain is synchronised first.
  assign pins_raw = {fault_flag_n_in, overcurrent_sense, high_supply_present,
                     over_temp, power_down_request_n, card_reset_n,
                     serial_latch, serial_clk, serial_data};

  // Reset values of the synchroniser match the idle pin levels.
  // The active-low inputs rest high, so no false card reset, power-down
  // or fault is seen when reset ends.
  pcs_sync #(
    .WIDTH(12),
    .RESET_VAL(12'h818)
  ) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign data_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign latch_s = pins_s[2];
  assign card_reset_n_s = pins_s[3];
  assign pwrdn_pin_n_s = pins_s[4];
  assign over_temp_s = pins_s[5];
  assign high_present_s = pins_s[6];
  assign oc_s = pins_s[10:7];
  assign fault_pin_s = pins_s[11];

  // The serial clock is only sampled, never used as a clock.
  // Each host clock level must therefore span at least three core cycles
  // so that every rise is seen exactly once.
  // Data and clock share one synchroniser depth, so the bit taken at a
  // detected rise is the one the host set up before that rise.

  // Edge history of the synchronised link and fault inputs.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sclk_prev_q <= 1'b0;
      latch_prev_q <= 1'b0;
      over_temp_prev_q <= 1'b0;
      oc_prev_q <= 4'h0;
    end else begin
      sclk_prev_q <= sclk_s;
      latch_prev_q <= latch_s;
      over_temp_prev_q <= over_temp_s;
      oc_prev_q <= oc_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_q; // RULE1
  assign latch_rise = latch_s & ~latch_prev_q; // RULE2
  assign card_reset_active = ~card_reset_n_s; // RULE5

  // The host finishes the word with latch before its next clock rise,
  // so the word loaded here never holds a bit of the following word.
  pcs_shift #(
    .WIDTH(`PCS_WORD_W)
  ) u_shift (
    .core_clk(core_clk),
    .reset(reset),
    .shift_pulse(sclk_rise),
    .data_bit(data_s),
    .load_pulse(latch_rise), // RULE3
    .hold_grounded(card_reset_active), // RULE7
    .shift_q(shift_word),
    .active_q(active_word),
    .valid_q(word_valid)
  );

  // Word decode into levels, high-impedance and discharge per output.
  always @* begin
    // Priority, highest first: reset or no accepted word, then power-down
    // and overtemperature, then the decoded levels.
    // Grounding wins over floating because a card must lose its charge
    // before it is powered again; a floating output would keep it.
    grounded = card_reset_active | ~word_valid; // RULE5 RULE6 RULE17
    all_off = ~pwrdn_pin_n_s | ~active_word[`PCS_PWRDN_BIT] | over_temp_s; // RULE4 RULE10 RULE15
    case ({active_word[`PCS_VCC_A_LO], active_word[`PCS_VCC_A_HI]})
      2'h1: lvl_main_a = `PCS_LVL_3V3;
      2'h2: lvl_main_a = `PCS_LVL_5V;
      default: lvl_main_a = `PCS_LVL_GND;
    endcase
    case ({active_word[`PCS_VCC_B_LO], active_word[`PCS_VCC_B_HI]})
      2'h1: lvl_main_b = `PCS_LVL_3V3;
      2'h2: lvl_main_b = `PCS_LVL_5V;
      default: lvl_main_b = `PCS_LVL_GND;
    endcase
    case ({active_word[`PCS_VPP_A_LO], active_word[`PCS_VPP_A_HI]})
      2'h1: lvl_prog_a = active_word[`PCS_VPP_A_5V] ? `PCS_LVL_5V : `PCS_LVL_3V3;
      2'h2: lvl_prog_a = `PCS_LVL_12V;
      default: lvl_prog_a = `PCS_LVL_GND;
    endcase
    case ({active_word[`PCS_VPP_B_LO], active_word[`PCS_VPP_B_HI]})
      2'h1: lvl_prog_b = active_word[`PCS_VPP_B_5V] ? `PCS_LVL_5V : `PCS_LVL_3V3;
      2'h2: lvl_prog_b = `PCS_LVL_12V;
      default: lvl_prog_b = `PCS_LVL_GND;
    endcase
    // Program outputs with both select bits set float by themselves.
    hiz_d[0] = all_off; // RULE4
    hiz_d[1] = all_off | (active_word[`PCS_VPP_A_LO] & active_word[`PCS_VPP_A_HI]);
    hiz_d[2] = all_off; // RULE4
    hiz_d[3] = all_off | (active_word[`PCS_VPP_B_LO] & active_word[`PCS_VPP_B_HI]);
    // A floating output is never discharged; a ground selection is.
    discharge_d[0] = ~hiz_d[0] & (lvl_main_a == `PCS_LVL_GND); // RULE12
    discharge_d[1] = ~hiz_d[1] & (lvl_prog_a == `PCS_LVL_GND); // RULE12
    discharge_d[2] = ~hiz_d[2] & (lvl_main_b == `PCS_LVL_GND); // RULE12
    discharge_d[3] = ~hiz_d[3] & (lvl_prog_b == `PCS_LVL_GND); // RULE12
    if (grounded) begin
      hiz_d = 4'h0; // RULE5
      discharge_d = 4'hf; // RULE5
    end
    // The pump source moves to the high supply only while a program output
    // really delivers 12 V; grounded or floating outputs keep it on the
    // low supply input, so the high supply may be switched off meanwhile.
    pump_d[0] = high_present_s & ~grounded & ~hiz_d[1] & (lvl_prog_a == `PCS_LVL_12V); // RULE11
    pump_d[1] = high_present_s & ~grounded & ~hiz_d[3] & (lvl_prog_b == `PCS_LVL_12V); // RULE11
    any_fault = (|oc_s) | over_temp_s; // RULE8
  end

  // Each level is a two-bit code: 0 ground, 1 3.3 V, 2 5 V, 3 12 V.
  // The analog switch drivers follow these codes; break-before-make and
  // slew control are handled there, not in this logic.

  // Current limiting is reported per output and only where that output
  // is connected to a supply; a floating or discharging output has no
  // path for a limited current.

  // The fault flag is open drain: its data register stays low and only
  // the enable moves, so this block can never drive the flag high.

  // Switch control outputs; in the grounded state every level reads ground.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      card_main_supply_out_a_q <= `PCS_LVL_GND;
      card_main_supply_out_b_q <= `PCS_LVL_GND;
      card_program_supply_out_a_q <= `PCS_LVL_GND;
      card_program_supply_out_b_q <= `PCS_LVL_GND;
      output_hiz_q <= 4'h0;
      ground_switch_a_q <= 1'b1; // RULE17
      ground_switch_b_q <= 1'b1;
      ground_switch_c_q <= 1'b1;
      ground_switch_d_q <= 1'b1;
      current_limit_q <= 4'h0;
      pump_from_high_supply_q <= 2'h0;
      fault_flag_n_out_q <= 1'b0;
      fault_flag_n_oe_n_q <= 1'b1;
    end else begin
      card_main_supply_out_a_q <= grounded ? `PCS_LVL_GND : lvl_main_a; // RULE5
      card_main_supply_out_b_q <= grounded ? `PCS_LVL_GND : lvl_main_b;
      card_program_supply_out_a_q <= grounded ? `PCS_LVL_GND : lvl_prog_a;
      card_program_supply_out_b_q <= grounded ? `PCS_LVL_GND : lvl_prog_b;
      output_hiz_q <= hiz_d; // RULE4 RULE10
      ground_switch_a_q <= discharge_d[0]; // RULE5 RULE12
      ground_switch_b_q <= discharge_d[1];
      ground_switch_c_q <= discharge_d[2];
      ground_switch_d_q <= discharge_d[3];
      current_limit_q <= oc_s & ~hiz_d & ~discharge_d; // RULE9
      pump_from_high_supply_q <= pump_d; // RULE11
      fault_flag_n_out_q <= 1'b0;
      fault_flag_n_oe_n_q <= ~any_fault; // RULE8
    end
  end

  // Event bits: 3:0 overcurrent onset per output, 4 overtemperature onset,
  // 5 word accepted, 6 latch refused during card reset.

  // Event sources for the sticky status register.
  always @* begin
    events = {`PCS_EV_W{1'b0}};
    events[`PCS_EV_OC_LO+3:`PCS_EV_OC_LO] = oc_s & ~oc_prev_q;
    events[`PCS_EV_THERM] = over_temp_s & ~over_temp_prev_q;
    events[`PCS_EV_LATCH] = latch_rise & ~card_reset_active;
    events[`PCS_EV_REFUSED] = latch_rise & card_reset_active;
    status_rd = reg_read & (reg_addr == `PCS_OFS_STATUS);
  end

  // Status clears on read, but a new event in that cycle still sets.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status_q <= {`PCS_EV_W{1'b0}};
    end else begin
      status_q <= (status_rd ? {`PCS_EV_W{1'b0}} : status_q) | events;
    end
  end

  // Mask register; only this one accepts writes.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mask_q <= `PCS_MASK_RST;
    end else if (reg_write && (reg_addr == `PCS_OFS_MASK)) begin
      mask_q <= reg_wdata[`PCS_EV_W-1:0];
    end
  end

  // Register map; unused upper bits always read as zero.
  // Offset 0x00 holds the sticky events and clears when read.
  // Offset 0x04 holds the interrupt mask in the same layout.
  // Offset 0x08 shows the active word in bits 10:0 and its valid flag in bit 11.
  // Offset 0x0c shows the synchronised pin levels and the grounded state.
  // Offset 0x10 shows the shift register, so a word can be checked before its latch.

  // Read mux; unmapped offsets and cycles without a read return zero.
  always @* begin
    rdata_d = {`PCS_DATA_W{1'b0}};
    if (reg_read) begin
      case (reg_addr)
        `PCS_OFS_STATUS: rdata_d[`PCS_EV_W-1:0] = status_q;
        `PCS_OFS_MASK: rdata_d[`PCS_EV_W-1:0] = mask_q;
        `PCS_OFS_WORD: rdata_d = {4'h0, word_valid, active_word};
        `PCS_OFS_STATE: rdata_d = {7'h00, fault_pin_s, grounded,
                                   ~pwrdn_pin_n_s, high_present_s,
                                   over_temp_s, oc_s};
        `PCS_OFS_SHIFT: rdata_d = {5'h00, shift_word};
        default: rdata_d = {`PCS_DATA_W{1'b0}};
      endcase
    end
  end

  // The interrupt follows the masked status one cycle late, so a read that
  // clears the last set bit drops the interrupt two cycles after the strobe.

  // Read data and interrupt level, both registered.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= {`PCS_DATA_W{1'b0}};
      irq_q <= 1'b0;
    end else begin
      reg_rdata_q <= rdata_d;
      irq_q <= |(status_q & mask_q);
    end
  end

endmodule

`default_nettype wire

// ===== src/pcs_regs.vh
`ifndef PCS_REGS_VH
`define PCS_REGS_VH

// Serial control word layout.
`define PCS_WORD_W 11
`define PCS_WORD_RST 11'h000
`define PCS_VPP_A_LO 0
`define PCS_VPP_A_HI 1
`define PCS_VCC_A_HI 2
`define PCS_VCC_A_LO 3
`define PCS_VPP_B_LO 4
`define PCS_VPP_B_HI 5
`define PCS_VCC_B_LO 6
`define PCS_VCC_B_HI 7
`define PCS_PWRDN_BIT 8
`define PCS_VPP_A_5V 9
`define PCS_VPP_B_5V 10

// Output level codes.
`define PCS_LVL_GND 2'h0
`define PCS_LVL_3V3 2'h1
`define PCS_LVL_5V 2'h2
`define PCS_LVL_12V 2'h3

// Register map, byte offsets.
`define PCS_ADDR_W 5
`define PCS_DATA_W 16
`define PCS_OFS_STATUS 5'h00
`define PCS_OFS_MASK 5'h04
`define PCS_OFS_WORD 5'h08
`define PCS_OFS_STATE 5'h0c
`define PCS_OFS_SHIFT 5'h10

// Event bits of the status and mask registers.
`define PCS_EV_W 7
`define PCS_EV_OC_LO 0
`define PCS_EV_THERM 4
`define PCS_EV_LATCH 5
`define PCS_EV_REFUSED 6
`define PCS_MASK_RST 7'h00

// Synchroniser depth.
`define PCS_SYNC_STAGES 2

`endif

// ===== src/pcs_shift.v
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.vh"

module pcs_shift #(
  parameter WIDTH = `PCS_WORD_W
) (
  input wire core_clk,
  input wire reset,
  input wire shift_pulse,
  input wire data_bit,
  input wire load_pulse,
  input wire hold_grounded,
  output reg [WIDTH-1:0] shift_q,
  output reg [WIDTH-1:0] active_q,
  output reg valid_q
);

  // Serial stage: oldest bit moves toward the top on every clock rise.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      shift_q <= {WIDTH{1'b0}};
    end else if (shift_pulse) begin
      shift_q <= {shift_q[WIDTH-2:0], data_bit}; // RULE1 RULE16
    end
  end

  // Active word: taken on latch rise, refused while the card reset holds.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      active_q <= {WIDTH{1'b0}};
      valid_q <= 1'b0; // RULE17
    end else if (hold_grounded) begin
      valid_q <= 1'b0; // RULE6 RULE7
    end else if (load_pulse) begin
      active_q <= shift_q; // RULE2
      valid_q <= 1'b1; // RULE6
    end
  end

endmodule

`default_nettype wire

// ===== src/pcs_sync.v
`timescale 1ns/1ps
`default_nettype none

module pcs_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire core_clk,
  input wire reset,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;

  // Two flip-flops per bit; only the second stage is visible outside.
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q;
      reg stable_q;
      always @(posedge core_clk or posedge reset) begin
        if (reset) begin
          meta_q <= RESET_VAL[i];
          stable_q <= RESET_VAL[i];
        end else begin
          meta_q <= async_in[i];
          stable_q <= meta_q;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate

endmodule

`default_nettype wire

// ===== verif/pcs_card_power_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.vh"
module pcs_card_power_ctrl_test;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic card_reset_n = 1'b1;
  logic power_down_request_n = 1'b1;
  logic over_temp = 1'b0;
  logic high_supply_present = 1'b1;
  logic [3:0] overcurrent_sense = 4'h0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  wire serial_data, serial_clk, serial_latch, fault_flag_n_out_q, fault_flag_n_oe_n_q, irq_q;
  wire ground_switch_a_q, ground_switch_b_q, ground_switch_c_q, ground_switch_d_q;
  wire [1:0] card_main_supply_out_a_q, card_main_supply_out_b_q, pump_from_high_supply_q;
  wire [1:0] card_program_supply_out_a_q, card_program_supply_out_b_q;
  wire [3:0] output_hiz_q, current_limit_q;
  wire [15:0] reg_rdata_q;
  // Flag wire with its pull-up, read back by the block.
  wire fault_wire = fault_flag_n_oe_n_q ? 1'b1 : fault_flag_n_out_q;
  wire [17:0] obs = {card_main_supply_out_a_q, card_program_supply_out_a_q, card_main_supply_out_b_q,
    card_program_supply_out_b_q, output_hiz_q, ground_switch_a_q, ground_switch_b_q,
    ground_switch_c_q, ground_switch_d_q, pump_from_high_supply_q};
  // Main A powers at 5 V first, is grounded, and only then goes to 3.3 V.
  logic [10:0] wv [4] = '{11'h33a, 11'h100, 11'h156, 11'h056};
  logic [17:0] we [4] = '{18'h28208, 18'h0003c, 18'h16c02, 18'h003c0};
  logic [17:0] wm [4] = '{18'h3f3ff, 18'h3ffff, 18'h3ffff, 18'h003ff};
  int n_fail = 0;
  int checks_done = 0;
  always #50 core_clk = ~core_clk;
  pcs_host_model i_pcs_host_model (.serial_data, .serial_clk, .serial_latch);
  pcs_card_power_ctrl i_pcs_card_power_ctrl (
    .core_clk, .reset, .serial_data, .serial_clk, .serial_latch, .card_reset_n,
    .power_down_request_n, .over_temp, .high_supply_present, .overcurrent_sense,
    .fault_flag_n_in(fault_wire), .fault_flag_n_out_q, .fault_flag_n_oe_n_q,
    .card_main_supply_out_a_q, .card_main_supply_out_b_q, .card_program_supply_out_a_q,
    .card_program_supply_out_b_q, .output_hiz_q, .ground_switch_a_q, .ground_switch_b_q,
    .ground_switch_c_q, .ground_switch_d_q, .current_limit_q, .pump_from_high_supply_q,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata_q, .irq_q
  );
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 chk(nm, reg_rdata_q, e);
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    close_out;
  end
  // Main sequence.
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    tick(1);
    chk("grounded", obs, 18'h0003c);
    chk("flag", fault_wire, 1'b1);
    rd("mask", `PCS_OFS_MASK, 16'h0000);
    rd("word", `PCS_OFS_WORD, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      i_pcs_host_model.send(wv[i], 400);
      tick(10);
      chk("outputs", obs & wm[i], we[i]);
      rd("shift", `PCS_OFS_SHIFT, {5'h00, wv[i]});
      rd("word", `PCS_OFS_WORD, {4'h0, 1'b1, wv[i]});
    end
    rd("status", `PCS_OFS_STATUS, 16'h0020);
    i_pcs_host_model.send(wv[2], 400);
    rd("unmapped", 5'h14, 16'h0000);
    wr(`PCS_OFS_WORD, 16'h0000);
    rd("word", `PCS_OFS_WORD, 16'h0956);
    wr(`PCS_OFS_MASK, 16'h0004);
    overcurrent_sense <= 4'h4;
    tick(8);
    chk("limit", current_limit_q, 4'h4);
    chk("flag", fault_wire, 1'b0);
    chk("irq", irq_q, 1'b1);
    overcurrent_sense <= 4'h0;
    tick(8);
    chk("flag", fault_wire, 1'b1);
    rd("status", `PCS_OFS_STATUS, 16'h0024);
    tick(2);
    chk("irq", irq_q, 1'b0);
    wr(`PCS_OFS_MASK, 16'h0000);
    over_temp <= 1'b1;
    tick(10);
    chk("thermal", obs & 18'h003ff, 18'h003c0);
    chk("flag", fault_wire, 1'b0);
    chk("irq", irq_q, 1'b0);
    over_temp <= 1'b0;
    tick(10);
    chk("outputs", obs, 18'h16c02);
    rd("status", `PCS_OFS_STATUS, 16'h0010);
    power_down_request_n <= 1'b0;
    tick(10);
    chk("pin off", obs & 18'h003ff, 18'h003c0);
    power_down_request_n <= 1'b1;
    card_reset_n <= 1'b0;
    tick(10);
    chk("card reset", obs, 18'h0003c);
    i_pcs_host_model.send(wv[1], 400);
    tick(10);
    chk("no latch", obs, 18'h0003c);
    rd("status", `PCS_OFS_STATUS, 16'h0040);
    card_reset_n <= 1'b1;
    tick(10);
    chk("held", obs, 18'h0003c);
    i_pcs_host_model.send(wv[2], 400);
    tick(10);
    chk("relatch", obs, 18'h16c02);
    high_supply_present <= 1'b0;
    tick(8);
    chk("pump", pump_from_high_supply_q, 2'b00);
    close_out;
  end
endmodule
`default_nettype wire

// ===== verif/pcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcs_host_model (
  output logic serial_data,
  output logic serial_clk,
  output logic serial_latch
);
  // Link idles with the clock still.
  initial begin
    serial_data = 1'b0;
    serial_clk = 1'b0;
    serial_latch = 1'b0;
  end
  // Shifts one word, top bit first, then latches before any new clock rise.
  task automatic send(input logic [10:0] w, input int hp);
    #17;
    for (int i = 10; i >= 0; i--) begin
      serial_data = w[i];
      #(hp) serial_clk = 1'b1;
      #(hp) serial_clk = 1'b0;
    end
    serial_data = ~w[0]; // Hold time is over, so the old bit is gone.
    #(hp) serial_latch = 1'b1;
    #(hp) serial_latch = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verif/pcs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pcs_monitor (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic card_reset_n,
  input wire logic power_down_request_n,
  input wire logic over_temp,
  input wire logic [3:0] overcurrent_sense,
  input wire logic fault_flag_n_oe_n_q,
  input wire logic [1:0] card_program_supply_out_b_q,
  input wire logic [3:0] output_hiz_q,
  input wire logic ground_switch_a_q,
  input wire logic ground_switch_b_q,
  input wire logic ground_switch_c_q,
  input wire logic ground_switch_d_q,
  input wire logic [3:0] current_limit_q,
  input wire logic [1:0] pump_from_high_supply_q,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata_q,
  input wire logic irq_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Grounded state: every discharge switch closed and nothing floating.
  wire gnd_all = ground_switch_a_q && ground_switch_b_q && ground_switch_c_q && ground_switch_d_q
    && output_hiz_q == 4'h0;
  // Sync and decode latency is at most three cycles, so the repeats leave margin.
  a_release_grounded: assert property ($fell(reset) |-> gnd_all)
    else $error("outputs not grounded after reset release");
  a_card_reset_gnd: assert property (!card_reset_n [*5] |-> gnd_all)
    else $error("card reset did not ground outputs");
  a_hiz_no_discharge: assert property (output_hiz_q[0] |-> !ground_switch_a_q)
    else $error("discharge closed on a floating output");
  a_fault_raise: assert property ((|overcurrent_sense || over_temp) [*6] |-> !fault_flag_n_oe_n_q)
    else $error("fault flag not pulled low");
  a_fault_clear: assert property ((overcurrent_sense == 4'h0 && !over_temp) [*6] |-> fault_flag_n_oe_n_q)
    else $error("fault flag low without a fault");
  a_limit_only: assert property ($stable(overcurrent_sense) [*6] |->
    (current_limit_q & ~overcurrent_sense) == 4'h0)
    else $error("limit on an output without overcurrent");
  a_thermal_off: assert property (over_temp [*8] |-> output_hiz_q == 4'hf || gnd_all)
    else $error("outputs on during overtemperature");
  a_pin_shutdown: assert property (!power_down_request_n [*8] |-> output_hiz_q == 4'hf || gnd_all)
    else $error("outputs on during pin shutdown");
  a_pump_high: assert property (pump_from_high_supply_q[1] |->
    card_program_supply_out_b_q == 2'h3 && !output_hiz_q[3])
    else $error("pump source without high supply selected");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata_q == 16'h0000)
    else $error("read data outside the read answer cycle");
  // Main scenarios reached.
  cover property (irq_q);
  cover property (current_limit_q != 4'h0);
  cover property (pump_from_high_supply_q[1]);
endmodule
bind pcs_card_power_ctrl pcs_monitor i_pcs_monitor (
  .core_clk, .reset, .card_reset_n, .power_down_request_n, .over_temp, .overcurrent_sense,
  .fault_flag_n_oe_n_q, .card_program_supply_out_b_q, .output_hiz_q, .ground_switch_a_q,
  .ground_switch_b_q, .ground_switch_c_q, .ground_switch_d_q, .current_limit_q,
  .pump_from_high_supply_q, .reg_read, .reg_rdata_q, .irq_q
);
`default_nettype wire
